// ---- logic/rhc_pkg.sv ----
package rhc_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL     = 12'h000;
   localparam logic [11:0] ADDR_LOCAL    = 12'h004;
   localparam logic [11:0] ADDR_CL       = 12'h008;
   localparam logic [11:0] ADDR_CLR_OUT  = 12'h00C;
   localparam logic [11:0] ADDR_MS_OUT   = 12'h010;
   localparam logic [11:0] ADDR_NPAR3    = 12'h014;
   localparam logic [11:0] ADDR_STATUS   = 12'h018;

   // ----------------------------------------------------------------------
   // Level 2 parameter bit positions (NPar(2) then SPar(2))
   // ----------------------------------------------------------------------
   localparam int BIT_UP_BAND    = 0;
   localparam int BIT_DN_BAND    = 1;
   localparam int BIT_OAM_CLEAR  = 2;
   localparam int BIT_USED_UP    = 3;
   localparam int BIT_USED_DN    = 4;
   localparam int BIT_XFORM      = 5;
   localparam int BIT_CE         = 6;
   localparam int BIT_INTF_BANDS = 7;
   localparam int BIT_MODE_SEL   = 8;
   localparam int PAR_W          = 9;

   // CTRL register fields.
   localparam int CTRL_CL_LOAD   = 0;
   localparam int CTRL_CLR_SEND  = 1;
   localparam int CTRL_MS_BUILD  = 2;
   localparam int CTRL_DONE      = 3;
   localparam int CTRL_PREF_DN   = 4;
   localparam int CTRL_HS_RESET  = 5;

   // NPar(3) field layout: transform size in low half, CE length in high half.
   localparam int XF_LSB         = 0;
   localparam int CE_LSB         = 16;
   localparam int FIELD_W        = 16;

   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      RHC_SILENT = 2'b00,
      RHC_HANDSHAKE = 2'b01,
      RHC_QUIET  = 2'b10
   } rhc_state_t;

endpackage

// ---- logic/rhc_composer.sv ----
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps

// Function
// (RULE_01) CLR clears used-band up, used-band down and interference-band bits.
// (RULE_02) CLR sets transform-size bit and carries own largest transform size.
// (RULE_03) Cleared CLR cyclic-extension bit means only mandatory extension length supported.
// (RULE_04) Set CLR cyclic-extension bit carries initial extension length in NPar(3).
// (RULE_05) If either end supports only mandatory extension, both use it.
// (RULE_06) MS selects this line mode by setting the Level 1 mode bit.
// (RULE_07) Every set Level 2 bit in MS has its NPar(3) field present.
// (RULE_08) Both band directions common: MS sets exactly one, remote chooses which.
// (RULE_09) No common band usage: MS clears both direction bits.
// (RULE_10) MS band direction bit set only if set in latest CL and CLR.
// (RULE_11) MS clear-channel OAM bit set only if set in both CL and CLR.
// (RULE_12) MS clears used-band up, used-band down and interference-band bits.
// (RULE_13) MS sets transform-size bit with largest commonly supported size.
// (RULE_14) MS extension bit cleared if cleared in CL or CLR.
// (RULE_15) MS extension bit set only if set in both, with length field.
// (RULE_16) CLR band direction bit means remote can use that band direction.
// (RULE_17) Handshake ending with this mode selected moves remote to quiet.
// (RULE_18) Keep latest received CL and latest sent CLR parameter bits.
module rhc_composer
   import rhc_pkg::*;
(
   input  wire logic        clk,      // System clock, 100 MHz.
   input  wire logic        rst,      // Synchronous reset, active high.
   input  wire logic        psel,     // APB select.
   input  wire logic        penable,  // APB enable.
   input  wire logic        pwrite,   // APB direction.
   input  wire logic [11:0] paddr,    // APB byte address.
   input  wire logic [31:0] pwdata,   // APB write data.
   output logic      [31:0] prdata,   // APB read data.
   output logic             pready,   // APB ready.
   output logic             pslverr,  // APB error on unmapped address.
   output logic             quiet     // Remote transceiver in quiet state.
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   logic [PAR_W-1:0]   local_cap;   // Own capability bits as configured.
   logic [FIELD_W-1:0] local_xf;    // Own largest transform size.
   logic [FIELD_W-1:0] local_ce;    // Own initial extension length.
   logic [PAR_W-1:0]   cl_bits;     // Office capabilities last received.
   logic [FIELD_W-1:0] cl_xf;       // Office largest transform size.
   logic [FIELD_W-1:0] cl_ce;       // Office extension length.
   logic [PAR_W-1:0]   clr_bits;    // CLR bits last sent.
   logic [31:0]        clr_npar3;   // CLR NPar(3) fields last sent.
   logic [PAR_W-1:0]   ms_bits;     // MS bits composed.
   logic [31:0]        ms_npar3;    // MS NPar(3) fields composed.
   logic               pref_dn;     // Band direction preference.
   logic               ms_valid;    // MS has been composed.
   rhc_state_t         state;

   logic        wr_en;
   logic        rd_en;
   logic        addr_ok;
   logic [31:0] rd_mux;
   logic [PAR_W-1:0] next_clr_bits;
   logic [PAR_W-1:0] next_ms_bits;
   logic [31:0]      next_ms_npar3;
   logic [31:0]      next_clr_npar3;
   logic             ctrl_wr;        // Access-phase write to CTRL.
   logic             clr_send;       // CLR latch strobe.
   logic             ms_build;       // MS latch strobe.

   function automatic logic [FIELD_W-1:0] min_f(input logic [FIELD_W-1:0] a,
                                                input logic [FIELD_W-1:0] b);
      min_f = (a < b) ? a : b;
   endfunction

   assign wr_en = psel && penable && pwrite && !pready;
   assign rd_en = psel && penable && !pwrite && !pready;

   // The pready gate makes a held access phase act once, so a command never repeats.
   assign ctrl_wr  = wr_en && (paddr == ADDR_CTRL);
   assign clr_send = ctrl_wr && pwdata[CTRL_CLR_SEND];
   assign ms_build = ctrl_wr && pwdata[CTRL_MS_BUILD];

   always_comb begin
      addr_ok = 1'b1;
      rd_mux  = RD_ZERO;
      case (paddr)
         ADDR_CTRL:    rd_mux = {26'h0, 5'h0, pref_dn};
         ADDR_LOCAL:   rd_mux = {local_ce, local_xf[FIELD_W-1:PAR_W], local_cap};
         ADDR_CL:      rd_mux = {cl_ce, cl_xf[FIELD_W-1:PAR_W], cl_bits};
         ADDR_CLR_OUT: rd_mux = {23'h0, clr_bits};
         ADDR_MS_OUT:  rd_mux = {22'h0, ms_valid, ms_bits};
         ADDR_NPAR3:   rd_mux = ms_npar3;
         ADDR_STATUS:  rd_mux = {30'h0, state};
         default:      addr_ok = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------------
   // APB slave: one wait state, answer in the second access cycle.
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         pready  <= 1'b0;
         prdata  <= RD_ZERO;
         pslverr <= 1'b0;
      end else begin
         pready  <= (wr_en || rd_en);
         pslverr <= (wr_en || rd_en) && !addr_ok;
         if (rd_en) begin
            prdata <= rd_mux;
         end
      end
   end

   // Local configuration. Field sizes share the word with the bit set.
   always_ff @(posedge clk) begin
      if (rst) begin
         local_cap <= '0;
         local_xf  <= '0;
         local_ce  <= '0;
         pref_dn   <= 1'b0;
      end else if (wr_en) begin
         if (paddr == ADDR_LOCAL) begin
            local_cap <= pwdata[PAR_W-1:0];
            local_xf  <= {pwdata[FIELD_W-1:PAR_W], {PAR_W{1'b0}}};
            local_ce  <= pwdata[CE_LSB +: FIELD_W];
         end
         if (paddr == ADDR_CTRL) begin
            pref_dn <= pwdata[CTRL_PREF_DN];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cl_bits <= '0;
         cl_xf   <= '0;
         cl_ce   <= '0;
      end else if (wr_en && paddr == ADDR_CL) begin
         cl_bits <= pwdata[PAR_W-1:0];                                      // RULE_18
         cl_xf   <= {pwdata[FIELD_W-1:PAR_W], {PAR_W{1'b0}}};
         cl_ce   <= pwdata[CE_LSB +: FIELD_W];
      end
   end

   // ----------------------------------------------------------------------
   // CLR composition
   // ----------------------------------------------------------------------
   always_comb begin
      next_clr_bits = local_cap;
      next_clr_bits[BIT_USED_UP]    = 1'b0;                                 // RULE_01
      next_clr_bits[BIT_USED_DN]    = 1'b0;                                 // RULE_01
      next_clr_bits[BIT_INTF_BANDS] = 1'b0;                                 // RULE_01
      next_clr_bits[BIT_XFORM]      = 1'b1;                                 // RULE_02
      next_clr_bits[BIT_MODE_SEL]   = 1'b1;
      // Band bits pass from own capability: a set bit claims usability.
      next_clr_npar3 = RD_ZERO;
      next_clr_npar3[XF_LSB +: FIELD_W] = local_xf;                         // RULE_02
      if (local_cap[BIT_CE]) begin
         next_clr_npar3[CE_LSB +: FIELD_W] = local_ce;                      // RULE_04
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         clr_bits  <= '0;
         clr_npar3 <= RD_ZERO;
      end else if (clr_send) begin
         clr_bits  <= next_clr_bits;                                        // RULE_16 RULE_18
         clr_npar3 <= next_clr_npar3;
      end
   end

   // ----------------------------------------------------------------------
   // MS composition from the latest CL and CLR
   // ----------------------------------------------------------------------
   always_comb begin
      logic up_c;
      logic dn_c;
      up_c = cl_bits[BIT_UP_BAND] && clr_bits[BIT_UP_BAND];                 // RULE_10
      dn_c = cl_bits[BIT_DN_BAND] && clr_bits[BIT_DN_BAND];                 // RULE_10
      next_ms_bits = '0;                                                    // RULE_12
      next_ms_bits[BIT_MODE_SEL] = 1'b1;                                    // RULE_06
      next_ms_bits[BIT_XFORM]    = 1'b1;                                    // RULE_13
      // The stored preference is used, so software must write it before the build strobe.
      if (up_c && dn_c) begin
         next_ms_bits[BIT_UP_BAND] = !pref_dn;                              // RULE_08
         next_ms_bits[BIT_DN_BAND] = pref_dn;                               // RULE_08
      end else begin
         next_ms_bits[BIT_UP_BAND] = up_c;                                  // RULE_09
         next_ms_bits[BIT_DN_BAND] = dn_c;                                  // RULE_09
      end
      next_ms_bits[BIT_OAM_CLEAR] = cl_bits[BIT_OAM_CLEAR] && clr_bits[BIT_OAM_CLEAR]; // RULE_11
      next_ms_bits[BIT_CE] = cl_bits[BIT_CE] && clr_bits[BIT_CE];          // RULE_14 RULE_15 RULE_05
      next_ms_npar3 = RD_ZERO;
      next_ms_npar3[XF_LSB +: FIELD_W] = min_f(cl_xf, clr_npar3[XF_LSB +: FIELD_W]); // RULE_13 RULE_07
      if (next_ms_bits[BIT_CE]) begin
         // Mandatory length is implied when the bit is clear, so no field is sent.
         next_ms_npar3[CE_LSB +: FIELD_W] = min_f(cl_ce, clr_npar3[CE_LSB +: FIELD_W]); // RULE_15 RULE_07 RULE_03
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ms_bits  <= '0;
         ms_npar3 <= RD_ZERO;
         ms_valid <= 1'b0;
      end else if (ms_build) begin
         ms_bits  <= next_ms_bits;
         ms_npar3 <= next_ms_npar3;
         ms_valid <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Handshake outcome
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= RHC_SILENT;
      end else if (wr_en && paddr == ADDR_CTRL) begin
         if (pwdata[CTRL_HS_RESET]) begin
            state <= RHC_SILENT;
         end else if (pwdata[CTRL_DONE] && ms_valid) begin
            state <= RHC_QUIET;                                             // RULE_17
         end else if (pwdata[CTRL_CLR_SEND]) begin
            state <= RHC_HANDSHAKE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         quiet <= 1'b0;
      end else begin
         quiet <= (state == RHC_QUIET);
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_clr_fixed_bits: assert property (@(posedge clk) disable iff (rst) // RULE_01
      !clr_bits[BIT_USED_UP] && !clr_bits[BIT_USED_DN] && !clr_bits[BIT_INTF_BANDS])
      else $error("CLR fixed band bits not clear");
   a_clr_xform_set: assert property (@(posedge clk) disable iff (rst) // RULE_02
      (wr_en && paddr == ADDR_CTRL && pwdata[CTRL_CLR_SEND]) |=> clr_bits[BIT_XFORM]
      && clr_npar3[XF_LSB +: FIELD_W] == $past(local_xf))
      else $error("CLR transform size wrong");
   a_clr_ce_field: assert property (@(posedge clk) disable iff (rst) // RULE_04
      !clr_bits[BIT_CE] |-> clr_npar3[CE_LSB +: FIELD_W] == '0)
      else $error("CLR extension field without bit");
   a_ms_one_dir: assert property (@(posedge clk) disable iff (rst) // RULE_08
      ms_valid |-> !(ms_bits[BIT_UP_BAND] && ms_bits[BIT_DN_BAND]))
      else $error("MS sets both band directions");
   a_ms_band_common: assert property (@(posedge clk) disable iff (rst) // RULE_10
      (wr_en && paddr == ADDR_CTRL && pwdata[CTRL_MS_BUILD]) |=>
      (!ms_bits[BIT_UP_BAND] || $past(cl_bits[BIT_UP_BAND] && clr_bits[BIT_UP_BAND])))
      else $error("MS band bit not common");
   a_ms_oam_common: assert property (@(posedge clk) disable iff (rst) // RULE_11
      (wr_en && paddr == ADDR_CTRL && pwdata[CTRL_MS_BUILD]) |=>
      ms_bits[BIT_OAM_CLEAR] == $past(cl_bits[BIT_OAM_CLEAR] && clr_bits[BIT_OAM_CLEAR]))
      else $error("MS OAM bit mismatch");
   a_ms_fixed_bits: assert property (@(posedge clk) disable iff (rst) // RULE_12
      ms_valid |-> !ms_bits[BIT_USED_UP] && !ms_bits[BIT_USED_DN] && !ms_bits[BIT_INTF_BANDS]
      && ms_bits[BIT_XFORM] && ms_bits[BIT_MODE_SEL])
      else $error("MS fixed bits wrong");
   a_ms_ce_common: assert property (@(posedge clk) disable iff (rst) // RULE_14
      (wr_en && paddr == ADDR_CTRL && pwdata[CTRL_MS_BUILD]) |=>
      ms_bits[BIT_CE] == $past(cl_bits[BIT_CE] && clr_bits[BIT_CE]))
      else $error("MS extension bit mismatch");
   a_quiet_entry: assert property (@(posedge clk) disable iff (rst) // RULE_17
      (state == RHC_QUIET) |=> quiet)
      else $error("Quiet output late");
   a_quiet_after_ms: assert property (@(posedge clk) disable iff (rst) // RULE_17
      quiet |-> ms_valid)
      else $error("Quiet entered without a mode select");
   a_hs_reset: assert property (@(posedge clk) disable iff (rst)
      (ctrl_wr && pwdata[CTRL_HS_RESET]) |=> state == RHC_SILENT)
      else $error("Handshake reset ignored");
   a_state_legal: assert property (@(posedge clk) disable iff (rst)
      state inside {RHC_SILENT, RHC_HANDSHAKE, RHC_QUIET})
      else $error("Illegal handshake state");

   // ----------------------------------------------------------------------
   // Composition checks
   // ----------------------------------------------------------------------
   a_clr_band_pass: assert property (@(posedge clk) disable iff (rst) // RULE_16
      clr_send |=> clr_bits[BIT_UP_BAND] == $past(local_cap[BIT_UP_BAND])
      && clr_bits[BIT_DN_BAND] == $past(local_cap[BIT_DN_BAND]))
      else $error("CLR band bits differ from capability");
   a_clr_ce_mand: assert property (@(posedge clk) disable iff (rst) // RULE_03
      (clr_send && !local_cap[BIT_CE]) |=> !clr_bits[BIT_CE])
      else $error("CLR claims unsupported extension lengths");
   a_clr_ce_len: assert property (@(posedge clk) disable iff (rst) // RULE_04
      (clr_send && local_cap[BIT_CE]) |=> clr_bits[BIT_CE]
      && clr_npar3[CE_LSB +: FIELD_W] == $past(local_ce))
      else $error("CLR extension length missing");
   a_cl_kept: assert property (@(posedge clk) disable iff (rst) // RULE_18
      (wr_en && paddr == ADDR_CL) |=> cl_bits == $past(pwdata[PAR_W-1:0]))
      else $error("Received CL bits not kept");
   a_ms_band_dn: assert property (@(posedge clk) disable iff (rst) // RULE_10
      ms_build |=>
      (!ms_bits[BIT_DN_BAND] || $past(cl_bits[BIT_DN_BAND] && clr_bits[BIT_DN_BAND])))
      else $error("MS downstream band bit not common");
   a_ms_pick_one: assert property (@(posedge clk) disable iff (rst) // RULE_08
      (ms_build && cl_bits[BIT_UP_BAND] && clr_bits[BIT_UP_BAND]
      && cl_bits[BIT_DN_BAND] && clr_bits[BIT_DN_BAND])
      |=> ms_bits[BIT_UP_BAND] != ms_bits[BIT_DN_BAND])
      else $error("MS did not pick exactly one band direction");
   a_ms_no_common: assert property (@(posedge clk) disable iff (rst) // RULE_09
      (ms_build && !(cl_bits[BIT_UP_BAND] && clr_bits[BIT_UP_BAND])
      && !(cl_bits[BIT_DN_BAND] && clr_bits[BIT_DN_BAND]))
      |=> !ms_bits[BIT_UP_BAND] && !ms_bits[BIT_DN_BAND])
      else $error("MS band bit set without common use");
   a_ms_xform_min: assert property (@(posedge clk) disable iff (rst) // RULE_13
      ms_build |=> ms_npar3[XF_LSB +: FIELD_W] <= $past(cl_xf)
      && ms_npar3[XF_LSB +: FIELD_W] <= $past(clr_npar3[XF_LSB +: FIELD_W])
      && (ms_npar3[XF_LSB +: FIELD_W] == $past(cl_xf)
      || ms_npar3[XF_LSB +: FIELD_W] == $past(clr_npar3[XF_LSB +: FIELD_W])))
      else $error("MS transform size not the common largest");
   a_ms_ce_len: assert property (@(posedge clk) disable iff (rst) // RULE_15
      ms_build |=> (ms_bits[BIT_CE] ? (ms_npar3[CE_LSB +: FIELD_W] <= $past(cl_ce)
      && ms_npar3[CE_LSB +: FIELD_W] <= $past(clr_npar3[CE_LSB +: FIELD_W]))
      : ms_npar3[CE_LSB +: FIELD_W] == '0))
      else $error("MS extension length wrong");

   // ----------------------------------------------------------------------
   // Bus checks
   // ----------------------------------------------------------------------
   // A second ready cycle would let the master take a stale answer.
   a_ready_pulse: assert property (@(posedge clk) disable iff (rst)
      pready |=> !pready)
      else $error("Ready held for two cycles");
   a_ready_answer: assert property (@(posedge clk) disable iff (rst)
      (wr_en || rd_en) |=> pready)
      else $error("Ready missing after access");
   a_err_qualified: assert property (@(posedge clk) disable iff (rst)
      pslverr |-> pready)
      else $error("Error flag without ready");
   a_unmapped_read: assert property (@(posedge clk) disable iff (rst)
      (rd_en && !addr_ok) |=> pslverr && prdata == RD_ZERO)
      else $error("Unmapped read not refused");
   a_unmapped_write: assert property (@(posedge clk) disable iff (rst)
      (wr_en && !addr_ok) |=> pslverr)
      else $error("Unmapped write not refused");

endmodule // rhc_composer

// ---- testbench/rhc_office_model.sv ----
`timescale 1ns/10ps

module rhc_office_model
   import rhc_pkg::*;
(
   input  wire logic        clk,     // System clock.
   input  wire logic        new_cl,  // Draw a fresh CL message at this edge.
   output logic      [31:0] cl_word  // Office CL in the LOCAL register layout.
);
   // --------------------------------------------------------------------
   // Office capability list
   // --------------------------------------------------------------------
   logic [8:0] caps;

   always @(posedge clk) begin
      if (new_cl) begin
         caps = 9'($urandom());
         // An office end limited to the mandatory extension reports no length.
         if (!caps[BIT_CE]) begin
            cl_word <= {16'h0000, 7'($urandom_range(1, 127)), caps};
         end else begin
            cl_word <= {16'($urandom_range(1, 65535)), 7'($urandom_range(1, 127)), caps};
         end
      end
   end
endmodule // rhc_office_model

// ---- testbench/remote_handshake_param_composer_test.sv ----
`timescale 1ns/10ps

module remote_handshake_param_composer_test;
   import rhc_pkg::*;

   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} rhc_note_t;

   logic        clk     = 1'b0;
   logic        rst     = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic        new_cl  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata, cl_word, loc, loc2, np;
   logic        pready, pslverr, quiet, pref;
   logic [9:0]  ms;
   logic [6:0]  xs;
   logic [15:0] ce;
   rhc_note_t   notes[$];
   rhc_note_t   n;
   int          fail_count = 0;
   int          tests_run  = 0;

   always #5 clk = ~clk;

   rhc_composer u_dut (
      .clk     (clk),
      .rst     (rst),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .quiet   (quiet)
   );

   rhc_office_model u_office (
      .clk     (clk),
      .new_cl  (new_cl),
      .cl_word (cl_word)
   );

   // --------------------------------------------------------------------
   // Reporting and bus tasks
   // --------------------------------------------------------------------
   task automatic fail(input string s);
      fail_count++;
      $display("[FAIL] %0t %s", $time, s);
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Every ready pulse must match exactly one queued note, so a stray or doubled pulse shows up too.
   always @(posedge clk) begin
      if (pready === 1'b1) begin
         tests_run++;
         if (notes.size() == 0) begin
            fail("ready without a request");
         end else begin
            n = notes.pop_front();
            if ((prdata & n.m) !== (n.d & n.m) || pslverr !== n.e) begin
               fail("read data or error flag differs");
            end
         end
      end
   end

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] m = 32'h0000_0000, input logic e = 1'b0);
      int k;
      notes.push_back('{d, m, e});
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         fail("no ready");
         complete_run();
      end else begin
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic wait_quiet(input logic v);
      int k;
      k = 0;
      while (quiet !== v && k < 10) begin
         @(posedge clk);
         k++;
      end
      tests_run++;
      if (quiet !== v) begin
         fail("quiet level wrong");
         complete_run();
      end
   endtask

   function automatic logic [9:0] ms_exp(input logic [8:0] r, input logic [8:0] c, input logic pd);
      logic [1:0] b;
      b = r[1:0] & c[1:0];
      if (b == 2'b11) b = pd ? 2'b10 : 2'b01;
      return {2'b11, 1'b0, r[6] & c[6], 1'b1, 2'b00, r[2] & c[2], b};
   endfunction

   // --------------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------------
   initial begin
      void'($urandom(96619));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, ADDR_STATUS, 32'h0000_0000, 32'h0000_0003);
      wait_quiet(1'b0);
      for (int i = 0; i < 24; i++) begin
         loc = {16'($urandom_range(1, 65535)), 7'($urandom_range(1, 127)), 9'($urandom())};
         loc2 = {loc[31:9], 9'($urandom())};
         pref = 1'($urandom());
         new_cl <= 1'b1;
         @(posedge clk);
         new_cl <= 1'b0;
         @(posedge clk);
         apb(1'b1, ADDR_LOCAL, loc);
         apb(1'b1, ADDR_CL, cl_word);
         apb(1'b0, ADDR_CL, cl_word, 32'hFFFF_FFFF);
         apb(1'b1, ADDR_CTRL, 32'h0000_0002);
         apb(1'b0, ADDR_CLR_OUT, (loc & ~32'h0000_0098) | 32'h0000_0120, 32'h0000_01FF);
         apb(1'b0, ADDR_STATUS, 32'h0000_0001, 32'h0000_0003);
         // Changing the local bits after the CLR left must not alter the mode select.
         apb(1'b1, ADDR_LOCAL, loc2);
         // The preference must be stored before the build strobe that uses it.
         apb(1'b1, ADDR_CTRL, {27'h0, pref, 4'h0});
         apb(1'b0, ADDR_CTRL, {31'h0, pref}, 32'h0000_0001);
         apb(1'b1, ADDR_CTRL, 32'h0000_0004 | {27'h0, pref, 4'h0});
         ms = ms_exp(loc[8:0], cl_word[8:0], pref);
         xs = (loc[15:9] < cl_word[15:9]) ? loc[15:9] : cl_word[15:9];
         ce = (loc[31:16] < cl_word[31:16]) ? loc[31:16] : cl_word[31:16];
         np = {ms[6] ? ce : 16'h0000, xs, 9'h000};
         apb(1'b0, ADDR_MS_OUT, {22'h0, ms}, 32'h0000_03FF);
         apb(1'b0, ADDR_NPAR3, np, 32'hFFFF_FFFF);
      end
      apb(1'b1, ADDR_CTRL, 32'h0000_0008);
      wait_quiet(1'b1);
      apb(1'b0, ADDR_STATUS, 32'h0000_0002, 32'h0000_0003);
      apb(1'b1, ADDR_CTRL, 32'h0000_0020);
      wait_quiet(1'b0);
      apb(1'b0, 12'h01C, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
      apb(1'b1, 12'h020, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000, 32'h0000_0003);
      complete_run();
   end
endmodule // remote_handshake_param_composer_test
